// [rtl/hul_pkg.sv]
// package for the host uart link: frame format, rates, carriers
package hul_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BAUD_START = 115200;
  localparam int unsigned BAUD_MAX = 3000000;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  // bit period in clocks, rounded down to the nearest whole cycle
  localparam int unsigned DIV_START = CLK_HZ / BAUD_START;
  localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_START[DIV_W-1:0];
  localparam logic [DIV_W-1:0] DIV_FLOOR = DIV_MIN[DIV_W-1:0];
  localparam int unsigned BUF_DEPTH = 2;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hul_byte_type;

  typedef struct packed {
    logic load;
    logic [DIV_W-1:0] divisor;
  } hul_rate_type;

  typedef enum logic [1:0] {
    HUL_IDLE = 2'b00,
    HUL_START = 2'b01,
    HUL_DATA = 2'b10,
    HUL_STOP = 2'b11
  } hul_state_type;
endpackage : hul_pkg

// [rtl/hul_buf.sv]
// two-entry valid/ready buffer between user and serialiser
`timescale 1ns/1ps
module hul_buf #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // occupancy
  output logic [1:0] level
);
  logic [W-1:0] mem_reg [2];
  logic [W-1:0] mem_next [2];
  logic [1:0] cnt_reg, cnt_next;

  always_comb begin
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    if (out_valid && out_ready) begin
      mem_next[0] = mem_reg[1];
      cnt_next = cnt_next - 2'h1;
    end
    if (in_valid && in_ready) begin
      mem_next[cnt_next[0]] = in_data;
      cnt_next = cnt_next + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      cnt_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
    end
  end

  // full refuses even when draining: keeps ready free of out_ready
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[0];
  assign level = cnt_reg;
endmodule : hul_buf

// [rtl/hul_link.sv]
// host uart link: 8N1 transmitter and receiver, flow control, host irq
`timescale 1ns/1ps
module hul_link
  import hul_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial pins
  output logic UART_TX,
  input wire logic UART_RX,
  input wire logic UART_CTS_N,
  output logic UART_RTS_N,
  // host control
  output logic HOST_IRQ_OUT,
  input wire logic HIBERNATE_REQ_N,
  output logic HIBERNATE,
  input wire logic IRQ_PULSE_MODE,
  // rate change, applied by the command decoder above this block
  input wire hul_pkg::hul_rate_type RATE_SET,
  // transmit words, sent low byte first
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [15:0] TX_WORD,
  // received bytes
  output hul_pkg::hul_byte_type RX_BYTE,
  input wire logic RX_READY,
  output logic RX_OVERRUN,
  // transfer request
  input wire logic XFER_REQ
);
  ////////////////////////////////////////////////////////////////////////
  // rate
  logic [DIV_W-1:0] div_reg, div_next;
  always_comb begin
    div_next = div_reg;
    if (RATE_SET.load) begin
      div_next = (RATE_SET.divisor < DIV_FLOOR) ? DIV_FLOOR : RATE_SET.divisor;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg <= DIV_RESET;
    end else begin
      div_reg <= div_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // little-endian split of words into the buffer
  logic hi_pend_reg, hi_pend_next;
  logic b_in_valid, b_in_ready, b_out_valid, b_out_ready;
  logic [7:0] hi_byte_reg, hi_byte_next, b_in_data, b_out_data;
  always_comb begin
    hi_pend_next = hi_pend_reg;
    hi_byte_next = hi_byte_reg;
    b_in_valid = hi_pend_reg || (TX_VALID && !HIBERNATE);
    b_in_data = hi_pend_reg ? hi_byte_reg : TX_WORD[7:0];
    if (b_in_ready) begin
      if (hi_pend_reg) begin
        hi_pend_next = 1'b0;
      end else if (TX_VALID && !HIBERNATE) begin
        hi_pend_next = 1'b1;
        hi_byte_next = TX_WORD[15:8];
      end
    end
  end
  assign TX_READY = b_in_ready && !hi_pend_reg && !HIBERNATE;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_pend_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
    end else begin
      hi_pend_reg <= hi_pend_next;
      hi_byte_reg <= hi_byte_next;
    end
  end
  hul_buf #(.W(8)) u_buf (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(b_in_valid),
    .in_ready(b_in_ready),
    .in_data(b_in_data),
    .out_valid(b_out_valid),
    .out_ready(b_out_ready),
    .out_data(b_out_data),
    .level()
  );
  ////////////////////////////////////////////////////////////////////////
  // transmitter
  hul_state_type tx_st_reg, tx_st_next;
  logic [DIV_W-1:0] tx_cnt_reg, tx_cnt_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic tx_line_reg, tx_line_next, tx_tick;
  assign tx_tick = (tx_cnt_reg == '0);
  // a character starts only on cts low; mid-character it is finished
  assign b_out_ready = (tx_st_reg == HUL_IDLE) && !UART_CTS_N && !HIBERNATE;
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_tick ? '0 : tx_cnt_reg - 1'b1;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    tx_line_next = tx_line_reg;
    unique case (tx_st_reg)
      HUL_IDLE: begin
        tx_line_next = 1'b1;
        if (b_out_valid && b_out_ready) begin
          tx_sh_next = b_out_data;
          tx_line_next = 1'b0;
          tx_cnt_next = div_reg - 1'b1;
          tx_st_next = HUL_START;
        end
      end
      HUL_START: begin
        if (tx_tick) begin
          tx_line_next = tx_sh_reg[0];
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
          tx_bit_next = 3'h0;
          tx_cnt_next = div_reg - 1'b1;
          tx_st_next = HUL_DATA;
        end
      end
      HUL_DATA: begin
        if (tx_tick) begin
          tx_cnt_next = div_reg - 1'b1;
          if (tx_bit_reg == 3'h7) begin
            tx_line_next = 1'b1;
            tx_st_next = HUL_STOP;
          end else begin
            tx_line_next = tx_sh_reg[0];
            tx_sh_next = {1'b0, tx_sh_reg[7:1]};
            tx_bit_next = tx_bit_reg + 3'h1;
          end
        end
      end
      HUL_STOP: begin
        if (tx_tick) begin
          tx_st_next = HUL_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_st_reg <= HUL_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_line_reg <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      tx_line_reg <= tx_line_next;
    end
  end
  assign UART_TX = tx_line_reg;
  ////////////////////////////////////////////////////////////////////////
  // receiver, samples mid-bit
  hul_state_type rx_st_reg, rx_st_next;
  logic [DIV_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  hul_byte_type rx_out_reg, rx_out_next;
  logic ovr_reg, ovr_next, rx_tick;
  assign rx_tick = (rx_cnt_reg == '0);
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_tick ? '0 : rx_cnt_reg - 1'b1;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_out_next = rx_out_reg;
    ovr_next = ovr_reg;
    rx_out_next.valid = rx_out_reg.valid && !RX_READY;
    unique case (rx_st_reg)
      HUL_IDLE: begin
        if (!UART_RX && !HIBERNATE) begin
          rx_cnt_next = {1'b0, div_reg[DIV_W-1:1]};
          rx_st_next = HUL_START;
        end
      end
      HUL_START: begin
        if (rx_tick) begin
          rx_cnt_next = div_reg - 1'b1;
          rx_bit_next = 3'h0;
          rx_st_next = UART_RX ? HUL_IDLE : HUL_DATA;
        end
      end
      HUL_DATA: begin
        if (rx_tick) begin
          rx_sh_next = {UART_RX, rx_sh_reg[7:1]};
          rx_cnt_next = div_reg - 1'b1;
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7) begin
            rx_st_next = HUL_STOP;
          end
        end
      end
      HUL_STOP: begin
        if (rx_tick) begin
          rx_st_next = HUL_IDLE;
          if (UART_RX) begin
            // a held byte is overwritten; the overrun flag records it
            ovr_next = ovr_reg || rx_out_next.valid;
            rx_out_next.valid = 1'b1;
            rx_out_next.data = rx_sh_reg;
          end
        end
      end
    endcase
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_st_reg <= HUL_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_out_reg <= '0;
      ovr_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_out_reg <= rx_out_next;
      ovr_reg <= ovr_next;
    end
  end
  assign RX_BYTE = rx_out_reg;
  assign RX_OVERRUN = ovr_reg;
  ////////////////////////////////////////////////////////////////////////
  // flow control, irq and hibernate
  logic rts_n_reg, rts_n_next, irq_reg, irq_next, hib_reg, hib_next;
  always_comb begin
    hib_next = !HIBERNATE_REQ_N;
    // rts drops while a received byte waits, so the next one is throttled
    rts_n_next = rx_out_next.valid || hib_next;
    // pulse mode toggles the irq every cycle while a request is held, else a held level
    irq_next = !hib_next && (IRQ_PULSE_MODE ? (XFER_REQ && !irq_reg) : XFER_REQ);
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rts_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      hib_reg <= 1'b0;
    end else begin
      rts_n_reg <= rts_n_next;
      irq_reg <= irq_next;
      hib_reg <= hib_next;
    end
  end
  assign UART_RTS_N = rts_n_reg;
  assign HOST_IRQ_OUT = irq_reg;
  assign HIBERNATE = hib_reg;
  ////////////////////////////////////////////////////////////////////////
  // checks
  a_cts_holds_start: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_st_reg == HUL_IDLE && UART_CTS_N) |=> (tx_st_reg == HUL_IDLE))
    else $error("character started while cts high");
  a_start_bit_low: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_st_reg == HUL_START) |-> !UART_TX) else $error("start bit not low");
  a_stop_bit_high: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_st_reg == HUL_STOP) |-> UART_TX) else $error("stop bit not high");
  a_rate_floor: assert property (@(posedge CLK) disable iff (!RST_N)
    div_reg >= DIV_FLOOR) else $error("rate above limit");
  a_hib_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    !HIBERNATE_REQ_N |=> HIBERNATE && !HOST_IRQ_OUT && UART_RTS_N)
    else $error("hibernate not entered");
  a_irq_level: assert property (@(posedge CLK) disable iff (!RST_N)
    (!IRQ_PULSE_MODE && XFER_REQ && HIBERNATE_REQ_N) |=> HOST_IRQ_OUT)
    else $error("irq not raised");
  a_irq_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    (IRQ_PULSE_MODE && HOST_IRQ_OUT) |=> !HOST_IRQ_OUT) else $error("pulse irq held");
  a_rts_full: assert property (@(posedge CLK) disable iff (!RST_N)
    rx_out_reg.valid |-> UART_RTS_N) else $error("rts asserted while byte waits");
  a_le_order: assert property (@(posedge CLK) disable iff (!RST_N)
    (TX_VALID && TX_READY) |=> hi_pend_reg && hi_byte_reg == $past(TX_WORD[15:8]))
    else $error("high byte not queued second");
endmodule : hul_link

// [dv/hul_host.sv]
// host-side model: receives the device's serial output and sends frames to it
`timescale 1ns/1ps
module hul_host (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic dev_tx,
  output logic dev_rx,
  input wire logic dev_rts_n,
  // bit period in clocks, three-wire wiring
  input wire logic [15:0] div,
  input wire logic ignore_rts
);
  logic got_valid = 1'b0;
  logic got_err = 1'b0;
  logic [7:0] got_byte = 8'h00;
  logic [7:0] sh;
  initial dev_rx = 1'b1;
  ////////////////////////////////////////
  // receiver: centre sampling keeps it tolerant of the stop bit's extra cycle
  // it never sleeps and never pauses the device, so every character is kept
  always begin
    @(posedge clk);
    if (dev_tx === 1'b0) begin
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        sh[i] = dev_tx;
      end
      repeat (div) @(posedge clk);
      got_err <= (dev_tx !== 1'b1);
      got_byte <= sh;
      got_valid <= 1'b1;
      @(posedge clk);
      got_valid <= 1'b0;
    end
  end
  ////////////////////////////////////////
  // sender: waits for rts unless wired three-wire, where the device cannot pause it
  task automatic send_byte(input logic [7:0] b, output logic ok);
    int n;
    logic [9:0] frame;
    n = 0;
    frame = {1'b1, b, 1'b0};
    while (!ignore_rts && dev_rts_n !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 40000);
    for (int i = 0; i < 10; i++) begin
      dev_rx <= frame[i];
      repeat (div) @(posedge clk);
    end
  endtask : send_byte
endmodule : hul_host

// [dv/hul_link_tb_top.sv]
// testbench for the host uart link: words out, bytes in, flow control, irq, hibernate
`timescale 1ns/1ps
module hul_link_tb_top;
  import hul_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic UART_TX, UART_RX, UART_RTS_N, HOST_IRQ_OUT, HIBERNATE, TX_READY, RX_OVERRUN;
  logic UART_CTS_N = 1'b0;
  logic HIBERNATE_REQ_N = 1'b1;
  logic IRQ_PULSE_MODE = 1'b0;
  logic TX_VALID = 1'b0;
  logic RX_READY = 1'b1;
  logic XFER_REQ = 1'b0;
  logic ignore_rts = 1'b0;
  logic [15:0] TX_WORD = 16'h0000;
  logic [15:0] div = DIV_RESET;
  hul_rate_type RATE_SET = '0;
  hul_byte_type RX_BYTE;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  logic ok;
  logic seen;
  logic [7:0] b;
  always #10 CLK = ~CLK;
  hul_link dut (.CLK(CLK), .RST_N(RST_N), .UART_TX(UART_TX), .UART_RX(UART_RX),
    .UART_CTS_N(UART_CTS_N), .UART_RTS_N(UART_RTS_N), .HOST_IRQ_OUT(HOST_IRQ_OUT),
    .HIBERNATE_REQ_N(HIBERNATE_REQ_N), .HIBERNATE(HIBERNATE),
    .IRQ_PULSE_MODE(IRQ_PULSE_MODE), .RATE_SET(RATE_SET), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_WORD(TX_WORD), .RX_BYTE(RX_BYTE), .RX_READY(RX_READY),
    .RX_OVERRUN(RX_OVERRUN), .XFER_REQ(XFER_REQ));
  hul_host host (.clk(CLK), .dev_tx(UART_TX), .dev_rx(UART_RX), .dev_rts_n(UART_RTS_N),
    .div(div), .ignore_rts(ignore_rts));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic bound(input int n);
    if (n >= 40000) begin
      n_fail++;
      conclude();
    end
  endtask : bound
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  task automatic send_word(input logic [15:0] w);
    int n;
    n = 0;
    TX_WORD <= w;
    TX_VALID <= 1'b1;
    tx_q.push_back(w[7:0]);
    tx_q.push_back(w[15:8]);
    @(posedge CLK);
    while (TX_READY !== 1'b1 && n < 40000) begin
      @(posedge CLK);
      n++;
    end
    TX_VALID <= 1'b0;
    @(posedge CLK);
    bound(n);
  endtask : send_word
  task automatic rx_send(input logic [7:0] v);
    rx_q.push_back(v);
    host.send_byte(v, ok);
    bound(ok ? 0 : 40000);
  endtask : rx_send
  task automatic drain();
    int n;
    n = 0;
    while ((tx_q.size() != 0 || rx_q.size() != 0) && n < 40000) begin
      @(posedge CLK);
      n++;
    end
    bound(n);
  endtask : drain
  ////////////////////////////////////////
  // results are taken in arrival order, so a swapped byte pair shows at once
  always @(posedge CLK) begin
    if (host.got_valid === 1'b1) begin
      check("stop bit", host.got_err, 1'b0);
      check("tx byte", host.got_byte, tx_q.size() ? tx_q.pop_front() : 16'hffff);
    end
    if (RX_BYTE.valid === 1'b1 && RX_READY === 1'b1) begin
      check("rx byte", RX_BYTE.data, rx_q.size() ? rx_q.pop_front() : 16'hffff);
    end
  end
  ////////////////////////////////////////
  initial begin
    b = 8'($urandom(1408));
    cyc(20);
    check("tx in reset", UART_TX, 1'b1);
    RST_N <= 1'b1;
    cyc(2);
    check("rts after reset", UART_RTS_N, 1'b0);
    check("irq idle", HOST_IRQ_OUT, 1'b0);
    check("hibernate idle", HIBERNATE, 1'b0);
    send_word(16'($urandom));
    rx_send(8'($urandom));
    drain();
    // divisor below the floor must clamp to the fastest rate
    RATE_SET <= '{load: 1'b1, divisor: 16'h0005};
    @(posedge CLK);
    RATE_SET <= '0;
    div = DIV_FLOOR;
    for (int i = 0; i < 4; i++) begin
      send_word(16'($urandom));
      rx_send(8'($urandom));
    end
    drain();
    UART_CTS_N <= 1'b1;
    @(posedge CLK);
    send_word(16'($urandom));
    seen = 1'b0;
    repeat (64) begin
      @(posedge CLK);
      if (UART_TX !== 1'b1) seen = 1'b1;
    end
    check("hold on cts", seen, 1'b0);
    check("buffer full", TX_READY, 1'b0);
    UART_CTS_N <= 1'b0;
    drain();
    RX_READY <= 1'b0;
    rx_send(8'($urandom));
    cyc(4);
    check("rts on held byte", UART_RTS_N, 1'b1);
    RX_READY <= 1'b1;
    cyc(3);
    check("rts released", UART_RTS_N, 1'b0);
    XFER_REQ <= 1'b1;
    cyc(2);
    check("irq level", HOST_IRQ_OUT, 1'b1);
    IRQ_PULSE_MODE <= 1'b1;
    cyc(3);
    seen = HOST_IRQ_OUT;
    @(posedge CLK);
    check("irq edge", HOST_IRQ_OUT ^ seen, 1'b1);
    HIBERNATE_REQ_N <= 1'b0;
    cyc(2);
    check("hibernate", HIBERNATE, 1'b1);
    check("irq in hibernate", HOST_IRQ_OUT, 1'b0);
    check("tx ready in hibernate", TX_READY, 1'b0);
    check("rts in hibernate", UART_RTS_N, 1'b1);
    HIBERNATE_REQ_N <= 1'b1;
    XFER_REQ <= 1'b0;
    cyc(3);
    check("wake", HIBERNATE, 1'b0);
    check("irq dropped", HOST_IRQ_OUT, 1'b0);
    check("no overrun", RX_OVERRUN, 1'b0);
    // three-wire: host ignores rts, so a second byte lands on the held one
    ignore_rts <= 1'b1;
    RX_READY <= 1'b0;
    @(posedge CLK);
    rx_send(b);
    rx_send(~b);
    check("overrun", RX_OVERRUN, 1'b1);
    // the first byte was overwritten, so only the second one is still held
    void'(rx_q.pop_front());
    RX_READY <= 1'b1;
    drain();
    conclude();
  end
endmodule : hul_link_tb_top
